// ==== rtl/bktp_pkg.sv ====
// Constants for the buck tuning and protection register bank
package bktp_pkg;

	localparam int NUM_REGS = 15;
	localparam int ADDR_W   = 16;

	localparam int IDX_B1_SPAN  = 0;
	localparam int IDX_B1_GAIN  = 1;
	localparam int IDX_B2_SPAN  = 2;
	localparam int IDX_B2_GAIN  = 3;
	localparam int IDX_B3_SPAN  = 4;
	localparam int IDX_B3_GAIN  = 5;
	localparam int IDX_FAULT    = 6;
	localparam int IDX_OC       = 7;
	localparam int IDX_ONTIME   = 8;
	localparam int IDX_HFILT    = 9;
	localparam int IDX_HRISE    = 10;
	localparam int IDX_LFILT    = 11;
	localparam int IDX_FALL     = 12;
	localparam int IDX_PULLDOWN = 13;
	localparam int IDX_SWITCH   = 14;

	localparam logic [15:0] REG_OFFS [NUM_REGS] = '{
		16'h005a, 16'h005d, 16'h0063, 16'h0066, 16'h006c, 16'h006f,
		16'h0079, 16'h007a, 16'h007b, 16'h0084, 16'h0085, 16'h0086,
		16'h0087, 16'h008f, 16'h0091};
	localparam logic [7:0] REG_RST [NUM_REGS] = '{
		8'h1a, 8'h00, 8'h1a, 8'h00, 8'h1a, 8'h00,
		8'hf0, 8'hcc, 8'h19, 8'h37, 8'h55, 8'h36,
		8'h54, 8'h7e, 8'h1d};
	// Writable bits; all others are reserved
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'h80, 8'h01, 8'h80, 8'h01, 8'h80, 8'h01,
		8'he0, 8'hc0, 8'h1c, 8'h73, 8'hff, 8'h73,
		8'hff, 8'h02, 8'h01};

	localparam logic [15:0] STATUS_OFFS = 16'h0092;
	localparam int ST_PGOOD    = 0;
	localparam int ST_SWITCH   = 1;
	localparam int ST_BLANK    = 2;
	localparam int ST_PULL_LOW = 3;

	localparam int SPAN_BIT   = 7;
	localparam int GAIN_BIT   = 0;
	localparam int UV_BIT     = 7;
	localparam int OV_BIT     = 6;
	localparam int SC_BIT     = 5;
	localparam int NEG_OC_BIT = 7;
	localparam int POS_OC_BIT = 6;
	localparam int ONTIME_LSB = 2;
	localparam int FILT_LSB   = 4;
	localparam int DRV_LSB    = 0;
	localparam int T1_LSB     = 0;
	localparam int T2_LSB     = 2;
	localparam int T3_LSB     = 4;
	localparam int TOP_LSB    = 6;
	localparam int PULL_BIT   = 1;
	localparam int PSW_BIT    = 0;

	// Synchroniser lanes for analog status inputs
	localparam int SYNC_W      = 7;
	localparam int SI_SSTART   = 0;
	localparam int SI_VCHANGE  = 1;
	localparam int SI_SSTOP    = 2;
	localparam int SI_HV_ON    = 3;
	localparam int SI_DAC_ZERO = 4;
	localparam int SI_FCCM_EXT = 5;
	localparam int SI_PGOOD    = 6;

	localparam int CLK_HZ        = 20_000_000;
	localparam int BLANK_EXT_US  = 50;
	localparam int BLANK_EXT_CYC =
		(BLANK_EXT_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int BLANK_CNT_W   = 10;
	localparam int PG_HOLD_MS    = 1;
	localparam int PG_HOLD_CYC   = PG_HOLD_MS * (CLK_HZ / 1000);
	localparam int PG_CNT_W      = 16;

endpackage

// ==== rtl/bktp_blank_timer.sv ====
// Detection blanking: ramp activity plus a fixed extension
`timescale 1ns/1ps
`default_nettype none
module bktp_blank_timer (
	input  wire logic clk,     // 20 MHz clock
	input  wire logic nrst,    // Async reset, active low
	input  wire logic busy,    // Soft start, voltage change or soft stop
	output logic      blank_q  // Detection must be masked
);
	localparam logic [bktp_pkg::BLANK_CNT_W-1:0] EXT_LOAD =
		bktp_pkg::BLANK_CNT_W'(bktp_pkg::BLANK_EXT_CYC);

	logic [bktp_pkg::BLANK_CNT_W-1:0] cnt_q;
	logic [bktp_pkg::BLANK_CNT_W-1:0] cnt_d;
	logic                             blank_d;

	always_comb begin
		cnt_d = cnt_q;
		if (busy) begin
			cnt_d = EXT_LOAD;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		blank_d = busy | (cnt_q != '0);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q   <= '0;
			blank_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			blank_q <= blank_d;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/bktp_pg_qualify.sv ====
// Power-good qualification: high continuously for a hold time
`timescale 1ns/1ps
`default_nettype none
module bktp_pg_qualify #(
	parameter int HOLD_CYC = bktp_pkg::PG_HOLD_CYC
) (
	input  wire logic clk,    // 20 MHz clock
	input  wire logic nrst,   // Async reset, active low
	input  wire logic pgood,  // Synchronised power-good
	output logic      held_q  // Power-good held long enough
);
	localparam logic [bktp_pkg::PG_CNT_W-1:0] LIMIT =
		bktp_pkg::PG_CNT_W'(HOLD_CYC);

	logic [bktp_pkg::PG_CNT_W-1:0] cnt_q;
	logic [bktp_pkg::PG_CNT_W-1:0] cnt_d;
	logic                          held_d;

	always_comb begin
		cnt_d  = cnt_q;
		held_d = 1'b0;
		if (!pgood) begin
			cnt_d = '0;
		end else if (cnt_q < LIMIT) begin
			cnt_d = cnt_q + 1'b1;
		end
		held_d = pgood && (cnt_q >= LIMIT);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= '0;
			held_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			held_q <= held_d;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/bktp_regs.sv ====
// Buck tuning and protection register bank with control outputs
`timescale 1ns/1ps
`default_nettype none
module bktp_regs #(
	parameter int PG_HOLD_CYC = bktp_pkg::PG_HOLD_CYC
) (
	input  wire logic        clk,              // 20 MHz clock
	input  wire logic        nrst,             // Async reset, active low
	input  wire logic [15:0] reg_addr,         // Host register address
	input  wire logic [7:0]  reg_wdata,        // Host write data
	input  wire logic        reg_wr,           // Host write strobe
	input  wire logic        reg_rd,           // Host read strobe
	output logic      [7:0]  reg_rdata_q,      // Read data, next cycle
	input  wire logic [15:0] otp_addr,         // OTP load address
	input  wire logic [7:0]  otp_data,         // OTP load data
	input  wire logic        otp_wr,           // OTP load strobe
	input  wire logic        soft_start,       // Analog: soft start busy
	input  wire logic        dynamic_voltage_change, // Analog: ramp busy
	input  wire logic        soft_stop,        // Analog: soft stop busy
	input  wire logic        hv_buck_on,       // Analog: converter running
	input  wire logic        dac_at_zero,      // Analog: DAC count is 0
	input  wire logic        fccm_extend,      // Analog: forced-CCM tail
	input  wire logic        hv_pgood,         // Analog: power good
	output logic             first_buck_dac_span,      // Span select
	output logic             first_buck_output_gain,   // 2x gain
	output logic             second_buck_dac_span,     // Span select
	output logic             second_buck_output_gain,  // 2x gain
	output logic             third_buck_dac_span,      // Span select
	output logic             third_buck_output_gain,   // 2x gain
	output logic             undervoltage_detect_active_q, // UV live
	output logic             overvoltage_detect_active_q,  // OV live
	output logic             output_short_detect_enable,   // Short det
	output logic             negative_overcurrent_enable,  // Neg OC
	output logic             positive_overcurrent_enable,  // Pos OC
	output logic      [2:0]  light_load_ontime_code,   // DCM on-time
	output logic      [2:0]  high_gate_low_filter_time, // Filter code
	output logic      [1:0]  high_gate_mid_drive_strength, // T2 drive
	output logic      [1:0]  high_gate_outer_drive_strength, // T1/T3
	output logic      [1:0]  high_gate_rise_interval_one,   // Rise T1
	output logic      [1:0]  high_gate_rise_interval_two,   // Rise T2
	output logic      [1:0]  high_gate_rise_interval_three, // Rise T3
	output logic      [2:0]  low_gate_low_filter_time,  // Filter code
	output logic      [1:0]  low_gate_drive_strength,   // Drive
	output logic      [1:0]  low_gate_edge_interval,    // Edge time
	output logic      [1:0]  high_gate_fall_interval_one,   // Fall T1
	output logic      [1:0]  high_gate_fall_interval_two,   // Fall T2
	output logic      [1:0]  high_gate_fall_interval_three, // Fall T3
	output logic             pull_low_q,       // Low-side on while off
	output logic             supply_switch_q   // Close supply switch
);
	logic [7:0]                  regs_q [bktp_pkg::NUM_REGS];
	logic [7:0]                  regs_d [bktp_pkg::NUM_REGS];
	logic [bktp_pkg::SYNC_W-1:0] sync1_q;
	logic [bktp_pkg::SYNC_W-1:0] sync2_q;
	logic [bktp_pkg::SYNC_W-1:0] sync_in;
	logic [4:0]                  wr_hit;
	logic [4:0]                  rd_hit;
	logic [4:0]                  otp_hit;
	logic [7:0]                  rdata_d;
	logic [7:0]                  status_w;
	logic                        busy_w;
	logic                        blank_w;
	logic                        pg_held_w;
	logic                        off_w;
	logic                        uv_d;
	logic                        ov_d;
	logic                        pull_d;
	logic                        switch_d;

	// Returns {hit, index} for a bank address
	function automatic logic [4:0] reg_lookup(input logic [15:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < bktp_pkg::NUM_REGS; i++) begin
			if (a == bktp_pkg::REG_OFFS[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// Keeps reserved bits at their power-on values
	function automatic logic [7:0] merge_bits(input logic [3:0] i,
		input logic [7:0] d);
		return (d & bktp_pkg::REG_MASK[i]) |
			(bktp_pkg::REG_RST[i] & ~bktp_pkg::REG_MASK[i]);
	endfunction

	assign sync_in = {hv_pgood, fccm_extend, dac_at_zero, hv_buck_on,
		soft_stop, dynamic_voltage_change, soft_start};
	assign wr_hit  = reg_lookup(reg_addr);
	assign rd_hit  = wr_hit;
	assign otp_hit = reg_lookup(otp_addr);

	// Register file; an OTP load wins over a host write in the same cycle
	always_comb begin
		regs_d = regs_q;
		if (otp_wr && otp_hit[4]) begin
			regs_d[otp_hit[3:0]] = merge_bits(otp_hit[3:0], otp_data);
		end else if (reg_wr && wr_hit[4]) begin
			regs_d[wr_hit[3:0]] = merge_bits(wr_hit[3:0], reg_wdata);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < bktp_pkg::NUM_REGS; i++) begin
				regs_q[i] <= bktp_pkg::REG_RST[i];
			end
		end else begin
			regs_q <= regs_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync_in;
			sync2_q <= sync1_q;
		end
	end

	assign busy_w = sync2_q[bktp_pkg::SI_SSTART] |
		sync2_q[bktp_pkg::SI_VCHANGE] | sync2_q[bktp_pkg::SI_SSTOP];

	bktp_blank_timer u_blank (
		.clk     (clk),
		.nrst    (nrst),
		.busy    (busy_w),
		.blank_q (blank_w)
	);

	bktp_pg_qualify #(
		.HOLD_CYC (PG_HOLD_CYC)
	) u_pg (
		.clk    (clk),
		.nrst   (nrst),
		.pgood  (sync2_q[bktp_pkg::SI_PGOOD]),
		.held_q (pg_held_w)
	);

	// Converter counts as off before start and after ramp-down completes
	assign off_w = ~sync2_q[bktp_pkg::SI_HV_ON] &
		sync2_q[bktp_pkg::SI_DAC_ZERO] & ~sync2_q[bktp_pkg::SI_FCCM_EXT];

	always_comb begin
		uv_d = regs_q[bktp_pkg::IDX_FAULT][bktp_pkg::UV_BIT] & ~blank_w;
		ov_d = regs_q[bktp_pkg::IDX_FAULT][bktp_pkg::OV_BIT] & ~blank_w;
		pull_d = regs_q[bktp_pkg::IDX_PULLDOWN][bktp_pkg::PULL_BIT] &
			off_w;
		switch_d = regs_q[bktp_pkg::IDX_SWITCH][bktp_pkg::PSW_BIT] &
			pg_held_w;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			undervoltage_detect_active_q <= 1'b0;
			overvoltage_detect_active_q  <= 1'b0;
			pull_low_q                   <= 1'b0;
			supply_switch_q              <= 1'b0;
		end else begin
			undervoltage_detect_active_q <= uv_d;
			overvoltage_detect_active_q  <= ov_d;
			pull_low_q                   <= pull_d;
			supply_switch_q              <= switch_d;
		end
	end

	always_comb begin
		status_w = 8'h00;
		status_w[bktp_pkg::ST_PGOOD]    = sync2_q[bktp_pkg::SI_PGOOD];
		status_w[bktp_pkg::ST_SWITCH]   = supply_switch_q;
		status_w[bktp_pkg::ST_BLANK]    = blank_w;
		status_w[bktp_pkg::ST_PULL_LOW] = pull_low_q;
	end

	// Read data holds between reads; unmapped reads return zero
	always_comb begin
		rdata_d = reg_rdata_q;
		if (reg_rd) begin
			if (rd_hit[4]) begin
				rdata_d = regs_q[rd_hit[3:0]];
			end else if (reg_addr == bktp_pkg::STATUS_OFFS) begin
				rdata_d = status_w;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end

	assign first_buck_dac_span =
		regs_q[bktp_pkg::IDX_B1_SPAN][bktp_pkg::SPAN_BIT];
	assign first_buck_output_gain =
		regs_q[bktp_pkg::IDX_B1_GAIN][bktp_pkg::GAIN_BIT];
	assign second_buck_dac_span =
		regs_q[bktp_pkg::IDX_B2_SPAN][bktp_pkg::SPAN_BIT];
	assign second_buck_output_gain =
		regs_q[bktp_pkg::IDX_B2_GAIN][bktp_pkg::GAIN_BIT];
	assign third_buck_dac_span =
		regs_q[bktp_pkg::IDX_B3_SPAN][bktp_pkg::SPAN_BIT];
	assign third_buck_output_gain =
		regs_q[bktp_pkg::IDX_B3_GAIN][bktp_pkg::GAIN_BIT];
	assign output_short_detect_enable =
		regs_q[bktp_pkg::IDX_FAULT][bktp_pkg::SC_BIT];
	assign negative_overcurrent_enable =
		regs_q[bktp_pkg::IDX_OC][bktp_pkg::NEG_OC_BIT];
	assign positive_overcurrent_enable =
		regs_q[bktp_pkg::IDX_OC][bktp_pkg::POS_OC_BIT];
	assign light_load_ontime_code =
		regs_q[bktp_pkg::IDX_ONTIME][bktp_pkg::ONTIME_LSB +: 3];
	assign high_gate_low_filter_time =
		regs_q[bktp_pkg::IDX_HFILT][bktp_pkg::FILT_LSB +: 3];
	assign high_gate_mid_drive_strength =
		regs_q[bktp_pkg::IDX_HFILT][bktp_pkg::DRV_LSB +: 2];
	assign high_gate_outer_drive_strength =
		regs_q[bktp_pkg::IDX_HRISE][bktp_pkg::TOP_LSB +: 2];
	assign high_gate_rise_interval_one =
		regs_q[bktp_pkg::IDX_HRISE][bktp_pkg::T1_LSB +: 2];
	assign high_gate_rise_interval_two =
		regs_q[bktp_pkg::IDX_HRISE][bktp_pkg::T2_LSB +: 2];
	assign high_gate_rise_interval_three =
		regs_q[bktp_pkg::IDX_HRISE][bktp_pkg::T3_LSB +: 2];
	assign low_gate_low_filter_time =
		regs_q[bktp_pkg::IDX_LFILT][bktp_pkg::FILT_LSB +: 3];
	assign low_gate_drive_strength =
		regs_q[bktp_pkg::IDX_LFILT][bktp_pkg::DRV_LSB +: 2];
	assign low_gate_edge_interval =
		regs_q[bktp_pkg::IDX_FALL][bktp_pkg::TOP_LSB +: 2];
	assign high_gate_fall_interval_one =
		regs_q[bktp_pkg::IDX_FALL][bktp_pkg::T1_LSB +: 2];
	assign high_gate_fall_interval_two =
		regs_q[bktp_pkg::IDX_FALL][bktp_pkg::T2_LSB +: 2];
	assign high_gate_fall_interval_three =
		regs_q[bktp_pkg::IDX_FALL][bktp_pkg::T3_LSB +: 2];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic host_only;
	assign host_only = reg_wr && !otp_wr;

	chk_span_write: assert property (
		host_only && reg_addr == 16'h005a
		|=> first_buck_dac_span == $past(reg_wdata[7]))
		else $error("first buck span not written");
	chk_gain_write: assert property (
		host_only && reg_addr == 16'h0066
		|=> second_buck_output_gain == $past(reg_wdata[0]))
		else $error("second buck gain not written");
	chk_third_span: assert property (
		host_only && reg_addr == 16'h006c
		|=> third_buck_dac_span == $past(reg_wdata[7]))
		else $error("third buck span not written");
	chk_uv_blanking: assert property (
		$rose(busy_w) |-> ##[1:3] !undervoltage_detect_active_q)
		else $error("uv not blanked during ramp");
	chk_ov_extension: assert property (
		$fell(busy_w) |=> !overvoltage_detect_active_q [*8])
		else $error("ov blanking extension too short");
	chk_short_disable: assert property (
		host_only && reg_addr == 16'h0079 && !reg_wdata[5]
		|=> !output_short_detect_enable)
		else $error("short detect not disabled");
	chk_negoc_write: assert property (
		host_only && reg_addr == 16'h007a
		|=> negative_overcurrent_enable == $past(reg_wdata[7]))
		else $error("negative oc enable not written");
	chk_ontime_write: assert property (
		host_only && reg_addr == 16'h007b
		|=> light_load_ontime_code == $past(reg_wdata[4:2]))
		else $error("on-time code not written");
	chk_reserved_hold: assert property (
		host_only && reg_addr == 16'h005a
		|=> regs_q[0][6:0] == 7'h1a)
		else $error("reserved bits changed by write");
	chk_pull_disabled: assert property (
		!regs_q[13][1] |=> !pull_low_q)
		else $error("pull-low active while disabled");
	chk_switch_wait: assert property (
		$rose(supply_switch_q) |-> $past(sync2_q[6], 1)
		&& $past(sync2_q[6], 8))
		else $error("supply switch closed before pgood held");

	cov_blank_seen: cover property ($rose(blank_w));
	cov_switch_on: cover property ($rose(supply_switch_q));
	cov_pull_low: cover property ($rose(pull_low_q));
endmodule
`default_nettype wire

// ==== testbench/bktp_analog_model.sv ====
// Behavioural analog side: ramps, converter state and power good
`timescale 1ns/1ps
`default_nettype none
module bktp_analog_model (
	input  wire logic       clk,                    // System clock
	input  wire logic [2:0] ramp_sel,               // Stop, change, start
	input  wire logic       run,                    // Converter commanded
	input  wire logic       pg_ok,                  // Output in regulation
	output logic            soft_start,             // Soft start busy
	output logic            dynamic_voltage_change, // Ramp busy
	output logic            soft_stop,              // Soft stop busy
	output logic            hv_buck_on,             // Converter running
	output logic            dac_at_zero,            // DAC count at zero
	output logic            fccm_extend,            // Forced-CCM tail
	output logic            hv_pgood                // Power good
);
	logic [3:0] tail_q = 4'h0;
	// DAC counts down after turn-off, then the forced-CCM tail runs out
	always @(posedge clk) begin
		if (run)
			tail_q <= 4'h8;
		else if (tail_q != 4'h0)
			tail_q <= tail_q - 4'h1;
	end
	assign {soft_stop, dynamic_voltage_change, soft_start} = ramp_sel;
	assign hv_buck_on  = run;
	assign dac_at_zero = !run && (tail_q < 4'h5);
	assign fccm_extend = !run && (tail_q != 4'h0);
	assign hv_pgood    = run && pg_ok;
endmodule
`default_nettype wire

// ==== testbench/test_buck_tuning_protection_regs.sv ====
// Self-checking bench for the buck tuning and protection register bank
`timescale 1ns/1ps
`default_nettype none
module test_buck_tuning_protection_regs;
	localparam int PG = 20;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] otp_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  otp_data = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        otp_wr = 1'b0;
	logic [2:0]  ramp_sel = 3'h0;
	logic        run = 1'b0;
	logic        pg_ok = 1'b0;
	wire  [7:0]  rdata;
	wire  [37:0] outs;
	wire         ss, vchg, sp, on, dz, fe, pg, uv, ov, pl, sw;
	logic [7:0]  e [bktp_pkg::NUM_REGS];
	int          failures = 0;
	int          total_checks = 0;

	always #25 clk = ~clk;

	bktp_analog_model model (.clk(clk), .ramp_sel(ramp_sel), .run(run),
		.pg_ok(pg_ok), .soft_start(ss), .dynamic_voltage_change(vchg),
		.soft_stop(sp), .hv_buck_on(on), .dac_at_zero(dz),
		.fccm_extend(fe), .hv_pgood(pg));

	bktp_regs #(.PG_HOLD_CYC(PG)) dut (.clk(clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(rdata), .otp_addr(otp_addr),
		.otp_data(otp_data), .otp_wr(otp_wr), .soft_start(ss),
		.dynamic_voltage_change(vchg), .soft_stop(sp), .hv_buck_on(on),
		.dac_at_zero(dz), .fccm_extend(fe), .hv_pgood(pg),
		.first_buck_dac_span(outs[37]), .first_buck_output_gain(outs[36]),
		.second_buck_dac_span(outs[35]),
		.second_buck_output_gain(outs[34]),
		.third_buck_dac_span(outs[33]), .third_buck_output_gain(outs[32]),
		.undervoltage_detect_active_q(uv),
		.overvoltage_detect_active_q(ov),
		.output_short_detect_enable(outs[31]),
		.negative_overcurrent_enable(outs[30]),
		.positive_overcurrent_enable(outs[29]),
		.light_load_ontime_code(outs[28:26]),
		.high_gate_low_filter_time(outs[25:23]),
		.high_gate_mid_drive_strength(outs[22:21]),
		.high_gate_outer_drive_strength(outs[20:19]),
		.high_gate_rise_interval_one(outs[18:17]),
		.high_gate_rise_interval_two(outs[16:15]),
		.high_gate_rise_interval_three(outs[14:13]),
		.low_gate_low_filter_time(outs[12:10]),
		.low_gate_drive_strength(outs[9:8]),
		.low_gate_edge_interval(outs[7:6]),
		.high_gate_fall_interval_one(outs[5:4]),
		.high_gate_fall_interval_two(outs[3:2]),
		.high_gate_fall_interval_three(outs[1:0]),
		.pull_low_q(pl), .supply_switch_q(sw));

	function automatic logic [37:0] exp_outs();
		return {e[0][7], e[1][0], e[2][7], e[3][0], e[4][7], e[5][0],
			e[6][5], e[7][7], e[7][6], e[8][4:2], e[9][6:4], e[9][1:0],
			e[10][7:6], e[10][1:0], e[10][3:2], e[10][5:4], e[11][6:4],
			e[11][1:0], e[12][7:6], e[12][1:0], e[12][3:2], e[12][5:4]};
	endfunction

	task automatic check(input string what, input logic [37:0] x,
		input logic [37:0] got);
		total_checks++;
		if (got !== x) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, x, got);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] x);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check("read data", 38'(x), 38'(rdata));
	endtask

	// Write a bank register and track what it should then hold
	task automatic wre(input int i, input logic [7:0] d);
		wr(bktp_pkg::REG_OFFS[i], d);
		e[i] = (e[i] & ~bktp_pkg::REG_MASK[i]) | (d & bktp_pkg::REG_MASK[i]);
	endtask

	task automatic read_all();
		for (int i = 0; i < bktp_pkg::NUM_REGS; i++)
			rd(bktp_pkg::REG_OFFS[i], e[i]);
		check("field outputs", exp_outs(), outs);
	endtask

	task automatic t_reset();
		for (int i = 0; i < bktp_pkg::NUM_REGS; i++)
			e[i] = bktp_pkg::REG_RST[i];
		read_all();
		check("uv ov pull switch", 38'h0e, 38'({uv, ov, pl, sw}));
		wr(16'h005b, 8'hff);
		rd(16'h0000, 8'h00);
		read_all();
	endtask

	task automatic t_fields();
		logic [7:0] pats [3] = '{8'hff, 8'h00, 8'ha5};
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < bktp_pkg::NUM_REGS; i++)
				wre(i, pats[p]);
			read_all();
		end
		for (int c = 0; c < 8; c++) begin
			wre(bktp_pkg::IDX_ONTIME, 8'(c << 2));
			wre(bktp_pkg::IDX_HFILT, 8'(c << 4));
			wre(bktp_pkg::IDX_LFILT, 8'(c << 4));
			check("code fields", exp_outs(), outs);
		end
		for (int i = 0; i < bktp_pkg::NUM_REGS; i++)
			wre(i, bktp_pkg::REG_RST[i]);
	endtask

	task automatic t_otp();
		@(negedge clk);
		otp_addr = bktp_pkg::REG_OFFS[bktp_pkg::IDX_B1_GAIN];
		reg_addr = otp_addr;
		otp_data = 8'h01;
		reg_wdata = 8'h00;
		otp_wr = 1'b1;
		reg_wr = 1'b1;
		@(negedge clk);
		otp_wr = 1'b0;
		reg_wr = 1'b0;
		e[bktp_pkg::IDX_B1_GAIN] = 8'h01;
		read_all();
		wre(bktp_pkg::IDX_B1_GAIN, 8'h00);
	endtask

	task automatic t_blank();
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			ramp_sel = 3'(1 << k);
			repeat (10) @(negedge clk);
			check("blank during ramp", 38'h0, 38'({uv, ov}));
			rd(bktp_pkg::STATUS_OFFS, 8'h0c);
			ramp_sel = 3'h0;
			repeat (998) @(negedge clk);
			check("blank extension", 38'h0, 38'({uv, ov}));
			repeat (14) @(negedge clk);
			check("blank over", 38'h3, 38'({uv, ov}));
		end
		wre(bktp_pkg::IDX_FAULT, 8'h70);
		repeat (3) @(negedge clk);
		check("uv disabled", 38'h1, 38'({uv, ov}));
		wre(bktp_pkg::IDX_FAULT, 8'hb0);
		repeat (3) @(negedge clk);
		check("ov disabled", 38'h2, 38'({uv, ov}));
		wre(bktp_pkg::IDX_FAULT, 8'hf0);
	endtask

	task automatic t_pull();
		run = 1'b1;
		repeat (6) @(negedge clk);
		check("pull low running", 38'h0, 38'(pl));
		run = 1'b0;
		repeat (5) @(negedge clk);
		check("pull low in tail", 38'h0, 38'(pl));
		repeat (12) @(negedge clk);
		check("pull low off", 38'h1, 38'(pl));
		rd(bktp_pkg::STATUS_OFFS, 8'h08);
		wre(bktp_pkg::IDX_PULLDOWN, 8'h00);
		repeat (4) @(negedge clk);
		check("pull low disabled", 38'h0, 38'(pl));
		wre(bktp_pkg::IDX_PULLDOWN, 8'h7e);
	endtask

	task automatic t_switch();
		run = 1'b1;
		pg_ok = 1'b1;
		repeat (PG) @(negedge clk);
		check("switch early", 38'h0, 38'(sw));
		repeat (6) @(negedge clk);
		check("switch closed", 38'h1, 38'(sw));
		rd(bktp_pkg::STATUS_OFFS, 8'h03);
		pg_ok = 1'b0;
		repeat (6) @(negedge clk);
		check("switch opened", 38'h0, 38'(sw));
		wre(bktp_pkg::IDX_SWITCH, 8'h00);
		pg_ok = 1'b1;
		repeat (3 * PG) @(negedge clk);
		check("switch disabled", 38'h0, 38'(sw));
		wre(bktp_pkg::IDX_SWITCH, 8'h1d);
		pg_ok = 1'b0;
		run = 1'b0;
	endtask

	initial begin
		#3_000_000;
		failures++;
		$display("MISMATCH watchdog expected done seen timeout");
		report_and_stop();
	end

	initial begin
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_fields();
		t_otp();
		t_blank();
		t_pull();
		t_switch();
		report_and_stop();
	end
endmodule
`default_nettype wire
